// >>> uefr_flag_reg.sv
`timescale 1ns/100ps
`default_nettype none

module uefr_flag_reg
    import uefr_pkg::*;
#(
    parameter int ADDR_W = 8
)
(
    input  wire logic              mclk,
    input  wire logic              srst,
    // APB slave
    input  wire logic              psel,
    input  wire logic              penable,
    input  wire logic              pwrite,
    input  wire logic [ADDR_W-1:0] paddr,
    input  wire logic [31:0]       pwdata,
    input  wire logic [3:0]        pstrb,
    output logic [31:0]            prdata,
    output logic                   pready,
    output logic                   pslverr,
    // Packet engine events and FIFO status, same clock
    input  wire logic              sof_rx,
    input  wire logic              ep3_out_xfer_done,
    input  wire logic              ep3_out_xfer_bad,
    input  wire logic              ep3_in_fifo_write,
    input  wire logic              ep3_in_token,
    input  wire logic              ep3_in_has_data,
    input  wire logic              ep2_in_token,
    input  wire logic [1:0]        ep2_in_fifo_empty,
    input  wire logic [1:0]        ep2_out_fifo_valid,
    // Interrupt requests
    output logic                   usb_irq_out_a_n,
    output logic                   usb_irq_out_b_n,
    output logic                   evt_irq
);

    // Register state
    logic [7:0]  ep2_flags_reg;
    logic [7:0]  ep2_flags_next;
    logic        ep3_in_treq_reg;
    logic        ep3_in_treq_next;
    logic        ep3_in_lost_reg;
    logic        ep3_in_lost_next;
    logic [7:0]  route_reg;
    logic [7:0]  evt_stat_reg;
    logic [7:0]  evt_stat_next;
    logic [7:0]  evt_mask_reg;
    logic [31:0] prdata_reg;
    logic        irq_a_n_reg;
    logic        irq_b_n_reg;
    logic        evt_irq_reg;
    logic        ep2_out_ready_d_reg;
    logic        ep2_in_empty_d_reg;

    // Outputs of the helper blocks
    wire         ep3_out_err;
    wire         ep3_out_ok;
    wire         ep3_out_publish;
    wire         ep3_in_lost_pulse;

    // Address match for one register word
    function automatic logic uefr_hit(input logic [ADDR_W-1:0] addr,
                                      input logic [7:0]        off);
        uefr_hit = (addr == ADDR_W'(off));
    endfunction

    // Bus decode
    wire acc_setup  = psel & ~penable;
    wire acc_commit = psel & penable;
    wire hit_flags  = uefr_hit(paddr, UEFR_OFF_FLAGS);
    wire hit_route  = uefr_hit(paddr, UEFR_OFF_ROUTE);
    wire hit_stat   = uefr_hit(paddr, UEFR_OFF_EVT_STAT);
    wire hit_mask   = uefr_hit(paddr, UEFR_OFF_EVT_MASK);
    wire hit_any    = hit_flags | hit_route | hit_stat | hit_mask;
    wire lane0_on   = pwrite & pstrb[0];
    wire wr_flags   = acc_commit & hit_flags & lane0_on;
    wire wr_route   = acc_commit & hit_route & lane0_on;
    wire wr_stat    = acc_commit & hit_stat & lane0_on;
    wire wr_mask    = acc_commit & hit_mask & lane0_on;

    // Software clear requests; only written zeros on clearable bits count
    wire [7:0] sw_clear = wr_flags ? (~pwdata[7:0] & UEFR_W0C_MASK) : 8'h00;

    // Hardware set events
    wire set_ep2_treq = ep2_in_token & (|ep2_in_fifo_empty);
    wire set_ep3_treq = ep3_in_token & ~ep3_in_has_data;
    wire ep2_out_ready = |ep2_out_fifo_valid;
    wire ep2_in_empty  = |ep2_in_fifo_empty;

    // Result of endpoint 3 out transfers, published at the following SOF
    uefr_ep3_out_result u_ep3_out (
        .mclk      (mclk),
        .srst      (srst),
        .xfer_done (ep3_out_xfer_done),
        .xfer_bad  (ep3_out_xfer_bad),
        .sof       (sof_rx),
        .rx_error  (ep3_out_err),
        .rx_ok     (ep3_out_ok),
        .publish   (ep3_out_publish)
    );

    // Watches written endpoint 3 in data that no IN token collects
    uefr_ep3_in_lost u_ep3_in (
        .mclk       (mclk),
        .srst       (srst),
        .fifo_write (ep3_in_fifo_write),
        .in_token   (ep3_in_token),
        .sof        (sof_rx),
        .lost       (ep3_in_lost_pulse)
    );

    // Sticky flags: set wins over the clear so an event in the clear cycle survives
    assign ep3_in_treq_next = set_ep3_treq
                            | (ep3_in_treq_reg & ~sw_clear[UEFR_BIT_ENDPOINT_THREE_IN_TREQ]);
    assign ep3_in_lost_next = ep3_in_lost_pulse
                            | (ep3_in_lost_reg & ~sw_clear[UEFR_BIT_ENDPOINT_THREE_IN_LOST]);

    // Endpoint 2 bits: bit 1 sticky, bits 2 and 0 track the FIFO status levels
    always_comb begin
        ep2_flags_next = 8'h00;
        ep2_flags_next[UEFR_BIT_ENDPOINT_TWO_IN_TREQ] = set_ep2_treq
            | (ep2_flags_reg[UEFR_BIT_ENDPOINT_TWO_IN_TREQ] & ~sw_clear[UEFR_BIT_ENDPOINT_TWO_IN_TREQ]);
        ep2_flags_next[UEFR_BIT_ENDPOINT_TWO_OUT_READY] = ep2_out_ready;
        ep2_flags_next[UEFR_BIT_ENDPOINT_TWO_IN_EMPTY] = ep2_in_empty;
    end

    // Assembled flag register view; the reserved bit is tied low
    wire [7:0] flags_view = {
        ep3_out_err,
        ep3_out_ok,
        ep3_in_lost_reg,
        ep3_in_treq_reg,
        1'b0,
        ep2_flags_reg[UEFR_BIT_ENDPOINT_TWO_OUT_READY],
        ep2_flags_reg[UEFR_BIT_ENDPOINT_TWO_IN_TREQ],
        ep2_flags_reg[UEFR_BIT_ENDPOINT_TWO_IN_EMPTY]
    };

    // Event sources for the maskable event register, same layout as the flags
    wire [7:0] evt_src = {
        ep3_out_publish & ep3_out_err,
        ep3_out_publish & ep3_out_ok,
        ep3_in_lost_pulse,
        set_ep3_treq,
        1'b0,
        ep2_out_ready & ~ep2_out_ready_d_reg,
        set_ep2_treq,
        ep2_in_empty & ~ep2_in_empty_d_reg
    };

    // Event status clears by writing one; a new event in that cycle still lands
    wire [7:0] evt_w1c = wr_stat ? pwdata[7:0] : 8'h00;
    assign evt_stat_next = evt_src | (evt_stat_reg & ~evt_w1c);

    // Per-bit routing of capable flags to the two request lines
    wire [7:0] req_to_a;
    wire [7:0] req_to_b;
    genvar gi;
    generate
        for (gi = 0; gi < 8; gi++) begin : g_route
            wire capable = UEFR_IRQ_CAPABLE[gi];
            assign req_to_a[gi] = flags_view[gi] & capable & ~route_reg[gi];
            assign req_to_b[gi] = flags_view[gi] & capable & route_reg[gi];
        end
    endgenerate

    // Read mux, sampled in the setup phase so prdata is a flop in the access phase
    wire [7:0] rd_byte = hit_flags ? flags_view
                       : hit_route ? route_reg
                       : hit_stat  ? evt_stat_reg
                       : hit_mask  ? evt_mask_reg
                       : 8'h00;

    // Flag storage
    always_ff @(posedge mclk) begin
        if (srst) begin
            ep2_flags_reg   <= UEFR_FLAGS_RESET;
            ep3_in_treq_reg <= 1'b0;
            ep3_in_lost_reg <= 1'b0;
        end else begin
            ep2_flags_reg   <= ep2_flags_next;
            ep3_in_treq_reg <= ep3_in_treq_next;
            ep3_in_lost_reg <= ep3_in_lost_next;
        end
    end

    // Software control registers
    always_ff @(posedge mclk) begin
        if (srst) begin
            route_reg    <= UEFR_ROUTE_RESET;
            evt_mask_reg <= UEFR_MASK_RESET;
        end else begin
            if (wr_route) begin
                route_reg <= pwdata[7:0];
            end
            if (wr_mask) begin
                evt_mask_reg <= pwdata[7:0];
            end
        end
    end

    // Event status and edge history for the level sources
    always_ff @(posedge mclk) begin
        if (srst) begin
            evt_stat_reg        <= UEFR_EVT_RESET;
            ep2_out_ready_d_reg <= 1'b0;
            ep2_in_empty_d_reg  <= 1'b1;
        end else begin
            evt_stat_reg        <= evt_stat_next;
            ep2_out_ready_d_reg <= ep2_out_ready;
            ep2_in_empty_d_reg  <= ep2_in_empty;
        end
    end

    // Read data register
    always_ff @(posedge mclk) begin
        if (srst) begin
            prdata_reg <= 32'h0000_0000;
        end else if (acc_setup) begin
            prdata_reg <= {24'h00_0000, rd_byte};
        end
    end

    // Interrupt outputs, registered to keep them glitch free
    always_ff @(posedge mclk) begin
        if (srst) begin
            irq_a_n_reg <= 1'b1;
            irq_b_n_reg <= 1'b1;
            evt_irq_reg <= 1'b0;
        end else begin
            irq_a_n_reg <= ~(|req_to_a);
            irq_b_n_reg <= ~(|req_to_b);
            evt_irq_reg <= |(evt_stat_next & evt_mask_reg);
        end
    end

    // Zero wait states; unmapped words answer with an error
    assign pready          = 1'b1;
    assign pslverr         = acc_commit & ~hit_any;
    assign prdata          = prdata_reg;
    assign usb_irq_out_a_n = irq_a_n_reg;
    assign usb_irq_out_b_n = irq_b_n_reg;
    assign evt_irq         = evt_irq_reg;

endmodule

`default_nettype wire

// >>> uefr_pkg.sv
package uefr_pkg;

    // Register byte offsets on the APB bus
    localparam logic [7:0] UEFR_OFF_FLAGS    = 8'h00;
    localparam logic [7:0] UEFR_OFF_ROUTE    = 8'h04;
    localparam logic [7:0] UEFR_OFF_EVT_STAT = 8'h08;
    localparam logic [7:0] UEFR_OFF_EVT_MASK = 8'h0c;

    // Bit positions inside the flag register
    localparam int UEFR_BIT_ENDPOINT_THREE_OUT_ERR   = 7;
    localparam int UEFR_BIT_ENDPOINT_THREE_OUT_OK    = 6;
    localparam int UEFR_BIT_ENDPOINT_THREE_IN_LOST  = 5;
    localparam int UEFR_BIT_ENDPOINT_THREE_IN_TREQ  = 4;
    localparam int UEFR_BIT_RSVD       = 3;
    localparam int UEFR_BIT_ENDPOINT_TWO_OUT_READY = 2;
    localparam int UEFR_BIT_ENDPOINT_TWO_IN_TREQ  = 1;
    localparam int UEFR_BIT_ENDPOINT_TWO_IN_EMPTY = 0;

    // Field masks of the flag register
    localparam logic [7:0] UEFR_W0C_MASK   = 8'h32;
    localparam logic [7:0] UEFR_IRQ_CAPABLE = 8'h37;
    localparam logic [7:0] UEFR_FLAGS_RESET = 8'h01;

    // Reset values of the software registers
    localparam logic [7:0] UEFR_ROUTE_RESET = 8'h00;
    localparam logic [7:0] UEFR_MASK_RESET  = 8'h00;
    localparam logic [7:0] UEFR_EVT_RESET   = 8'h00;

    // SOF packets after an endpoint 3 in write before the data counts as lost
    localparam logic [1:0] UEFR_SOF_LOST_COUNT = 2'h2;

    // States of the endpoint 3 in lost-data tracker
    typedef enum logic [1:0] {
        UEFR_LOST_IDLE  = 2'b01,
        UEFR_LOST_ARMED = 2'b10
    } uefr_lost_state_t;

endpackage

// >>> uefr_ep3_out_result.sv
`timescale 1ns/100ps
`default_nettype none

module uefr_ep3_out_result
    import uefr_pkg::*;
(
    input  wire logic mclk,
    input  wire logic srst,
    input  wire logic xfer_done,
    input  wire logic xfer_bad,
    input  wire logic sof,
    output logic      rx_error,
    output logic      rx_ok,
    output logic      publish
);

    logic pending_reg;
    logic pending_bad_reg;
    logic rx_error_reg;
    logic rx_ok_reg;
    logic publish_reg;

    // A result waits here until the next SOF; a transfer ending on the SOF cycle waits for the next
    wire pub_now = sof & pending_reg;

    always_ff @(posedge mclk) begin
        if (srst) begin
            pending_reg     <= 1'b0;
            pending_bad_reg <= 1'b0;
            rx_error_reg    <= 1'b0;
            rx_ok_reg       <= 1'b0;
            publish_reg     <= 1'b0;
        end else begin
            pending_reg <= xfer_done | (pending_reg & ~sof);
            if (xfer_done) begin
                pending_bad_reg <= xfer_bad;
            end
            if (pub_now) begin
                rx_error_reg <= pending_bad_reg;
                rx_ok_reg    <= ~pending_bad_reg;
            end
            publish_reg <= pub_now;
        end
    end

    assign rx_error = rx_error_reg;
    assign rx_ok    = rx_ok_reg;
    assign publish  = publish_reg;

endmodule

`default_nettype wire

// >>> uefr_ep3_in_lost.sv
`timescale 1ns/100ps
`default_nettype none

module uefr_ep3_in_lost
    import uefr_pkg::*;
(
    input  wire logic mclk,
    input  wire logic srst,
    input  wire logic fifo_write,
    input  wire logic in_token,
    input  wire logic sof,
    output logic      lost
);

    uefr_lost_state_t state_reg;
    uefr_lost_state_t state_next;
    logic [1:0]       sof_cnt_reg;
    logic [1:0]       sof_cnt_next;
    logic             lost_next;
    logic             lost_reg;

    // Count SOFs after a write; an IN token takes the data and disarms
    always_comb begin
        state_next   = state_reg;
        sof_cnt_next = sof_cnt_reg;
        lost_next    = 1'b0;
        unique case (state_reg)
            UEFR_LOST_IDLE: begin
                if (fifo_write) begin
                    state_next   = UEFR_LOST_ARMED;
                    sof_cnt_next = 2'h0;
                end
            end
            UEFR_LOST_ARMED: begin
                if (in_token) begin
                    state_next = UEFR_LOST_IDLE;
                end else if (sof) begin
                    sof_cnt_next = sof_cnt_reg + 2'h1;
                    if (sof_cnt_next == UEFR_SOF_LOST_COUNT) begin
                        lost_next  = 1'b1;
                        state_next = UEFR_LOST_IDLE;
                    end
                end
            end
            default: begin
                state_next = UEFR_LOST_IDLE;
            end
        endcase
    end

    always_ff @(posedge mclk) begin
        if (srst) begin
            state_reg   <= UEFR_LOST_IDLE;
            sof_cnt_reg <= 2'h0;
            lost_reg    <= 1'b0;
        end else begin
            state_reg   <= state_next;
            sof_cnt_reg <= sof_cnt_next;
            lost_reg    <= lost_next;
        end
    end

    assign lost = lost_reg;

endmodule

`default_nettype wire

// >>> uefr_flag_reg_props.sv
`timescale 1ns/100ps
`default_nettype none

module uefr_flag_reg_chk
    import uefr_pkg::*;
#(
    parameter int ADDR_W = 8
)
(
    input wire logic              mclk,
    input wire logic              srst,
    input wire logic              psel,
    input wire logic              penable,
    input wire logic              pwrite,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic [31:0]       prdata,
    input wire logic              pready,
    input wire logic              pslverr,
    input wire logic              ep3_in_token,
    input wire logic              ep3_in_has_data,
    input wire logic              ep2_in_token,
    input wire logic [1:0]        ep2_in_fifo_empty,
    input wire logic [1:0]        ep2_out_fifo_valid,
    input wire logic              usb_irq_out_a_n,
    input wire logic              usb_irq_out_b_n
);
    // Either line counts, since routing is up to software
    wire logic irq_any;
    assign irq_any = !usb_irq_out_a_n || !usb_irq_out_b_n;

    default clocking cb @(posedge mclk); endclocking
    default disable iff (srst);

    // Flag one edge after its cause, line one edge after the flag
    property p_ep2_treq;
        ep2_in_token && |ep2_in_fifo_empty |-> ##2 irq_any;
    endproperty
    a_ep2_treq: assert property (p_ep2_treq)
        else $error("ep2 token on empty fifo gave no irq");

    property p_ep3_treq;
        ep3_in_token && !ep3_in_has_data |-> ##2 irq_any;
    endproperty
    a_ep3_treq: assert property (p_ep3_treq)
        else $error("ep3 token without data gave no irq");

    property p_endpoint_two_out;
        |ep2_out_fifo_valid |-> ##2 irq_any;
    endproperty
    a_endpoint_two_out: assert property (p_endpoint_two_out)
        else $error("ep2 out data ready gave no irq");

    property p_endpoint_two_in;
        |ep2_in_fifo_empty |-> ##2 irq_any;
    endproperty
    a_endpoint_two_in: assert property (p_endpoint_two_in)
        else $error("ep2 in fifo empty gave no irq");

    // Data is captured at the setup edge
    property p_rsvd;
        psel && !penable && !pwrite && paddr == UEFR_OFF_FLAGS
            |=> !prdata[3] && prdata[31:8] == 24'h0;
    endproperty
    a_rsvd: assert property (p_rsvd)
        else $error("reserved flag bits read nonzero");

    property p_ready;
        pready;
    endproperty
    a_ready: assert property (p_ready)
        else $error("pready dropped");

    property p_err_phase;
        pslverr |-> psel && penable;
    endproperty
    a_err_phase: assert property (p_err_phase)
        else $error("pslverr outside access phase");

    property p_decode;
        psel && penable && paddr[1:0] == 2'b00 |-> pslverr == (paddr > 8'h0c);
    endproperty
    a_decode: assert property (p_decode)
        else $error("pslverr does not match address map");
endmodule

bind uefr_flag_reg uefr_flag_reg_chk #(.ADDR_W(ADDR_W)) u_chk (
    .mclk(mclk), .srst(srst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .ep3_in_token(ep3_in_token), .ep3_in_has_data(ep3_in_has_data),
    .ep2_in_token(ep2_in_token), .ep2_in_fifo_empty(ep2_in_fifo_empty),
    .ep2_out_fifo_valid(ep2_out_fifo_valid), .usb_irq_out_a_n(usb_irq_out_a_n),
    .usb_irq_out_b_n(usb_irq_out_b_n)
);

`default_nettype wire

// >>> uefr_usb_host.sv
`timescale 1ns/100ps
`default_nettype none

module uefr_usb_host
(
    input  wire logic       mclk,
    input  wire logic       srst,
    input  wire logic       fire,
    input  wire logic [2:0] kind,
    output logic            sof_rx,
    output logic            ep3_out_xfer_done,
    output logic            ep3_out_xfer_bad,
    output logic            ep3_in_fifo_write,
    output logic            ep3_in_token,
    output logic            ep2_in_token
);
    // Kinds: 0 SOF, 1/2 good/bad ep3 out, 3 ep3 in write, 4/5 ep3/ep2 IN token
    wire logic done;
    assign done = fire && (kind == 3'h1 || kind == 3'h2);

    // One-cycle pulses, as the packet engine gives them
    always_ff @(posedge mclk) begin
        sof_rx            <= fire && kind == 3'h0;
        ep3_out_xfer_done <= done;
        ep3_in_fifo_write <= fire && kind == 3'h3;
        ep3_in_token      <= fire && kind == 3'h4;
        ep2_in_token      <= fire && kind == 3'h5;
    end

    // Error level means nothing outside done, so it wanders there
    always_ff @(posedge mclk) begin
        if (srst || done) begin
            ep3_out_xfer_bad <= fire && kind == 3'h2;
        end else begin
            ep3_out_xfer_bad <= !ep3_out_xfer_bad;
        end
    end
endmodule

`default_nettype wire

// >>> test_usb_endpoint_flag_register.sv
`timescale 1ns/100ps
`default_nettype none

module test_usb_endpoint_flag_register
    import uefr_pkg::*;
;
    logic        mclk, srst, psel, penable, pwrite, pready, pslverr, serr, fire;
    logic        sof, xdone, xbad, fwr, tok3, tok2, has3, irq_a_n, irq_b_n, evt_irq;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata, rdat;
    logic [3:0]  pstrb;
    logic [2:0]  kind;
    logic [1:0]  emp2, val2;
    int          failures, n_compared;

    uefr_flag_reg #(.ADDR_W(8)) dut (
        .mclk(mclk), .srst(srst), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .sof_rx(sof), .ep3_out_xfer_done(xdone),
        .ep3_out_xfer_bad(xbad), .ep3_in_fifo_write(fwr), .ep3_in_token(tok3),
        .ep3_in_has_data(has3), .ep2_in_token(tok2), .ep2_in_fifo_empty(emp2),
        .ep2_out_fifo_valid(val2), .usb_irq_out_a_n(irq_a_n),
        .usb_irq_out_b_n(irq_b_n), .evt_irq(evt_irq)
    );

    uefr_usb_host host (
        .mclk(mclk), .srst(srst), .fire(fire), .kind(kind), .sof_rx(sof),
        .ep3_out_xfer_done(xdone), .ep3_out_xfer_bad(xbad), .ep3_in_fifo_write(fwr),
        .ep3_in_token(tok3), .ep2_in_token(tok2)
    );

    // 100 MHz clock
    initial begin
        mclk = 1'b0;
        forever #5 mclk = ~mclk;
    end

    task automatic close_out;
        $display("compared %0d mismatches %0d", n_compared, failures);
        if (failures == 0 && n_compared > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        n_compared++;
        if (got !== exp) begin
            failures++;
            $display("ERROR %s expected %h seen %h", what, exp, got);
        end
    endtask

    // One APB transfer; an idle edge after it keeps drivers from colliding
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        int n;
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge mclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge mclk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (n >= 20) begin
            failures++;
            close_out();
        end
        rdat = prdata;
        serr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge mclk);
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] exp, input string what);
        apb(1'b0, a, 32'h0);
        chk(what, exp, rdat);
    endtask

    // One packet-engine event, then time for flags and lines to settle
    task automatic ev(input logic [2:0] k);
        kind <= k;
        fire <= 1'b1;
        @(posedge mclk);
        fire <= 1'b0;
        repeat (4) @(posedge mclk);
    endtask

    // Registered outputs are looked at mid-cycle
    task automatic lines(input logic a, input logic b, input logic e);
        @(negedge mclk);
        chk("irq line a", {31'h0, a}, {31'h0, irq_a_n});
        chk("irq line b", {31'h0, b}, {31'h0, irq_b_n});
        chk("event irq", {31'h0, e}, {31'h0, evt_irq});
        @(posedge mclk);
    endtask

    initial begin
        failures = 0;
        n_compared = 0;
        srst <= 1'b1;
        {psel, penable, pwrite, fire, has3} <= 5'h0;
        paddr <= 8'h00;
        pwdata <= 32'h0;
        pstrb <= 4'hf;
        kind <= 3'h0;
        emp2 <= 2'b01;
        val2 <= 2'b00;
        repeat (5) @(posedge mclk);
        lines(1'b1, 1'b1, 1'b0);
        srst <= 1'b0;
        rd(UEFR_OFF_FLAGS, 32'h01, "flags after reset");
        rd(UEFR_OFF_ROUTE, 32'h0, "route after reset");
        rd(UEFR_OFF_EVT_STAT, 32'h0, "events after reset");
        rd(UEFR_OFF_EVT_MASK, 32'h0, "mask after reset");
        lines(1'b0, 1'b1, 1'b0);
        $display("test reset done");
        // Status bits follow FIFO levels and ignore writes
        emp2 <= 2'b00;
        val2 <= 2'b10;
        repeat (3) @(posedge mclk);
        rd(UEFR_OFF_FLAGS, 32'h04, "out ready");
        wr(UEFR_OFF_FLAGS, 32'h00);
        rd(UEFR_OFF_FLAGS, 32'h04, "status on write 0");
        wr(UEFR_OFF_FLAGS, 32'hff);
        rd(UEFR_OFF_FLAGS, 32'h04, "reserved on write 1");
        val2 <= 2'b00;
        emp2 <= 2'b10;
        repeat (3) @(posedge mclk);
        rd(UEFR_OFF_FLAGS, 32'h01, "in fifo empty");
        $display("test status done");
        // Transmit requests, clears by explicit mask, set beating clear
        ev(3'h5);
        rd(UEFR_OFF_FLAGS, 32'h03, "ep2 tx request");
        wr(UEFR_OFF_FLAGS, 32'hff);
        rd(UEFR_OFF_FLAGS, 32'h03, "write 1 kept");
        wr(UEFR_OFF_FLAGS, 32'hfd);
        rd(UEFR_OFF_FLAGS, 32'h01, "ep2 tx cleared");
        has3 <= 1'b1;
        ev(3'h4);
        rd(UEFR_OFF_FLAGS, 32'h01, "ep3 token with data");
        has3 <= 1'b0;
        ev(3'h4);
        rd(UEFR_OFF_FLAGS, 32'h11, "ep3 tx request");
        wr(UEFR_OFF_FLAGS, 32'hef);
        rd(UEFR_OFF_FLAGS, 32'h01, "ep3 tx cleared");
        ev(3'h5);
        fork
            ev(3'h5);
            wr(UEFR_OFF_FLAGS, 32'hfd);
        join
        rd(UEFR_OFF_FLAGS, 32'h03, "set beats clear");
        wr(UEFR_OFF_FLAGS, 32'hfd);
        $display("test requests done");
        // Endpoint 3 out results wait for SOF and never pull the request lines low
        emp2 <= 2'b00;
        ev(3'h2);
        rd(UEFR_OFF_FLAGS, 32'h00, "result before sof");
        ev(3'h0);
        rd(UEFR_OFF_FLAGS, 32'h80, "bad receive");
        lines(1'b1, 1'b1, 1'b0);
        wr(UEFR_OFF_FLAGS, 32'h00);
        rd(UEFR_OFF_FLAGS, 32'h80, "result write 0");
        ev(3'h1);
        rd(UEFR_OFF_FLAGS, 32'h80, "good before sof");
        ev(3'h0);
        rd(UEFR_OFF_FLAGS, 32'h40, "good receive");
        $display("test ep3 out done");
        // Unclaimed ep3 in data is lost at the second SOF
        ev(3'h3);
        ev(3'h0);
        rd(UEFR_OFF_FLAGS, 32'h40, "lost after one sof");
        ev(3'h0);
        rd(UEFR_OFF_FLAGS, 32'h60, "lost after two sof");
        lines(1'b0, 1'b1, 1'b0);
        wr(UEFR_OFF_FLAGS, 32'hdf);
        rd(UEFR_OFF_FLAGS, 32'h40, "lost cleared");
        has3 <= 1'b1;
        ev(3'h3);
        ev(3'h4);
        ev(3'h0);
        ev(3'h0);
        rd(UEFR_OFF_FLAGS, 32'h40, "token claims data");
        $display("test lost data done");
        // Event status, mask, routing and an unmapped access
        emp2 <= 2'b01;
        repeat (3) @(posedge mclk);
        wr(UEFR_OFF_EVT_STAT, 32'hff);
        rd(UEFR_OFF_EVT_STAT, 32'h0, "events cleared");
        wr(UEFR_OFF_EVT_MASK, 32'h02);
        ev(3'h5);
        rd(UEFR_OFF_EVT_STAT, 32'h02, "tx event");
        lines(1'b0, 1'b1, 1'b1);
        wr(UEFR_OFF_EVT_MASK, 32'h00);
        lines(1'b0, 1'b1, 1'b0);
        wr(UEFR_OFF_EVT_STAT, 32'h02);
        wr(UEFR_OFF_EVT_MASK, 32'h02);
        rd(UEFR_OFF_EVT_STAT, 32'h0, "event w1c");
        wr(UEFR_OFF_ROUTE, 32'h02);
        lines(1'b0, 1'b0, 1'b0);
        apb(1'b0, 8'h40, 32'h0);
        chk("unmapped error", 32'h1, {31'h0, serr});
        chk("unmapped data", 32'h0, rdat);
        $display("test events done");
        close_out();
    end
endmodule

`default_nettype wire
